// ---- core/cntm_ctrl.sv ----
// Mode, pin truth table and protection logic of a high-speed bus transceiver
// Notes on behaviour
// - Standby select low gives normal mode
// - Normal: transmit low drives bus dominant
// - Normal: receive output mirrors bus state
// - Standby: transmitter and receiver off, wake monitor
// - Standby receive high until wake, then follows
// - Select low returns to normal within 40us
// - Wake needs dominant, recessive, dominant phases
// - Whole pattern within timeout or detector resets
// - Filter noise and clamped dominant bus
// - No wake flag on normal, undervoltage, timeout
// - Long transmit low disables the transmitter
// - Transmit high clears the dominant timer
// - Floating transmit and select read high
// - Undervoltage forces standby, ignores select
// - Thermal shutdown holds until cool and transmit high
`timescale 1ns/100ps
`include "cntm_defs.svh"
module cntm_ctrl
  import cntm_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic txd_i,
  input wire logic txd_drv_i,
  input wire logic standby_select_i,
  input wire logic standby_select_drv_i,
  input wire logic bus_dom_i,
  input wire logic undervoltage_i,
  input wire logic thermal_shutdown_i,
  output logic rxd_o,
  output logic bus_drive_dom_o,
  output logic bus_bias_gnd_o,
  output logic normal_rx_en_o,
  output logic normal_mode_o,
  output logic dominant_timeout_o,
  output logic wake_flag_o
);
  localparam logic [`CNTM_CNT_W-1:0] DTO_C = `CNTM_CNT_W'(`CNTM_DOM_TO_CYC);
  localparam logic [`CNTM_CNT_W-1:0] RXS_C = `CNTM_CNT_W'(`CNTM_RXD_START_CYC);
  localparam logic [`CNTM_CNT_W-1:0] MODE_C = `CNTM_CNT_W'(`CNTM_MODE_CYC);

  cntm_wake_if wk ();

  cntm_mode_t mode_q, mode_d;
  logic [`CNTM_CNT_W-1:0] mcnt_q, mcnt_d;
  logic [`CNTM_CNT_W-1:0] dto_q, dto_d;
  logic dto_hit_q, dto_hit_d;
  logic tsd_q, tsd_d;
  logic [`CNTM_CNT_W-1:0] rxs_q, rxs_d;
  logic rx_follow_q, rx_follow_d;
  logic rxd_q, rxd_d;
  logic drv_q, drv_d;
  logic txd_eff, stb_eff, want_normal, tx_ok;
  logic in_normal, in_standby;

  // Undriven pins read as the weak pull-up would leave them
  assign txd_eff = txd_drv_i ? txd_i : 1'b1;
  assign stb_eff = standby_select_drv_i ? standby_select_i : 1'b1;
  // Supply loss overrides select
  assign want_normal = !stb_eff && !undervoltage_i;
  // Either protection keeps the driver off until transmit is seen high
  assign tx_ok = !dto_hit_q && !tsd_q && !thermal_shutdown_i;
  assign in_normal = (mode_q == CNTM_NORMAL);
  assign in_standby = (mode_q == CNTM_STANDBY);

  // Only the low-power receiver listens, and only on a good supply
  assign wk.arm = in_standby && !undervoltage_i;
  assign wk.bus_dom = bus_dom_i;

  // Pattern search restarts from idle each time it is armed
  cntm_wake_det cntm_wake_det_i (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .wk(wk)
  );

  // Mode selection with bounded transition delay
  always_comb begin
    mode_d = mode_q;
    mcnt_d = '0;
    if (undervoltage_i) begin
      mode_d = CNTM_STANDBY;
    end else begin
      unique case (mode_q)
        CNTM_NORMAL: begin
          if (stb_eff) begin
            mode_d = CNTM_STANDBY;
          end
        end
        CNTM_STANDBY: begin
          if (want_normal) begin
            // Short settling delay, well inside the 40 us bound
            mcnt_d = mcnt_q + `CNTM_CNT_W'(1);
            if (mcnt_q >= RXS_C || mcnt_q >= MODE_C - `CNTM_CNT_W'(1)) begin
              mode_d = CNTM_NORMAL;
              mcnt_d = '0;
            end
          end
        end
        // An upset code falls back to the passive mode
        default: begin
          mode_d = CNTM_STANDBY;
        end
      endcase
    end
  end

  // Reset lands in standby so the bus stays passive
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      mode_q <= CNTM_STANDBY;
      mcnt_q <= '0;
    end else if (ce_i) begin
      mode_q <= mode_d;
      mcnt_q <= mcnt_d;
    end
  end

  // Dominant timeout; the counter stops at its limit so it cannot wrap
  always_comb begin
    dto_d = dto_q;
    dto_hit_d = dto_hit_q;
    if (!in_normal || txd_eff) begin
      dto_d = '0;
    end else if (dto_q != DTO_C) begin
      dto_d = dto_q + `CNTM_CNT_W'(1);
    end
    if (in_normal && !txd_eff && dto_q == DTO_C) begin
      dto_hit_d = 1'b1;
    end else if (txd_eff) begin
      dto_hit_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      dto_q <= '0;
      dto_hit_q <= 1'b0;
    end else if (ce_i) begin
      dto_q <= dto_d;
      dto_hit_q <= dto_hit_d;
    end
  end

  // Thermal latch; a cooled die still waits for transmit high
  always_comb begin
    tsd_d = tsd_q;
    if (thermal_shutdown_i) begin
      tsd_d = 1'b1;
    end else if (txd_eff) begin
      tsd_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      tsd_q <= 1'b0;
    end else if (ce_i) begin
      tsd_q <= tsd_d;
    end
  end

  // Receiver settles a few microseconds after a wake in standby
  always_comb begin
    rxs_d = rxs_q;
    rx_follow_d = rx_follow_q;
    if (in_normal || !wk.detected) begin
      rxs_d = '0;
      rx_follow_d = 1'b0;
    end else if (rxs_q != RXS_C) begin
      rxs_d = rxs_q + `CNTM_CNT_W'(1);
    end else begin
      // Counter rests at its end value until the flag drops
      rx_follow_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rxs_q <= '0;
      rx_follow_q <= 1'b0;
    end else if (ce_i) begin
      rxs_q <= rxs_d;
      rx_follow_q <= rx_follow_d;
    end
  end

  // Pin truth table; standby ignores transmit entirely
  always_comb begin
    rxd_d = 1'b1;
    drv_d = 1'b0;
    if (in_normal) begin
      rxd_d = !bus_dom_i;
      drv_d = !txd_eff && tx_ok;
    end else if (wk.detected && rx_follow_q) begin
      rxd_d = !bus_dom_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rxd_q <= 1'b1;
      drv_q <= 1'b0;
    end else if (ce_i) begin
      rxd_q <= rxd_d;
      drv_q <= drv_d;
    end
  end

  // Analog enables follow the mode register directly
  assign rxd_o = rxd_q;
  assign bus_drive_dom_o = drv_q;
  assign bus_bias_gnd_o = in_standby;
  assign normal_rx_en_o = in_normal;
  assign normal_mode_o = in_normal;
  assign dominant_timeout_o = dto_hit_q;
  assign wake_flag_o = wk.detected;
endmodule : cntm_ctrl

// ---- core/cntm_defs.svh ----
// Timing constants for the transceiver mode and wake control block
`ifndef CNTM_DEFS_SVH
`define CNTM_DEFS_SVH
`define CNTM_CLK_HZ 25000000
`define CNTM_CLK_NS 40
// Wake phase time, ns (0.5 us least)
`define CNTM_WAKE_PHASE_NS 500
`define CNTM_WAKE_PHASE_CYC ((`CNTM_WAKE_PHASE_NS + `CNTM_CLK_NS - 1) / `CNTM_CLK_NS)
// Wake filter time, ns (1.8 us most)
`define CNTM_WAKE_FILT_NS 1800
`define CNTM_WAKE_FILT_CYC (`CNTM_WAKE_FILT_NS / `CNTM_CLK_NS)
// Wake pattern timeout, us (typ 3.0 ms)
`define CNTM_WAKE_TO_US 3000
`define CNTM_WAKE_TO_CYC (`CNTM_WAKE_TO_US * (`CNTM_CLK_HZ / 1000000))
// Dominant timeout, us (typ 2.0 ms)
`define CNTM_DOM_TO_US 2000
`define CNTM_DOM_TO_CYC (`CNTM_DOM_TO_US * (`CNTM_CLK_HZ / 1000000))
// Receive output valid delay after wake, us (4 least, 20 most)
`define CNTM_RXD_START_US 4
`define CNTM_RXD_START_CYC (`CNTM_RXD_START_US * (`CNTM_CLK_HZ / 1000000))
// Mode change time, us (40 most)
`define CNTM_MODE_US 40
`define CNTM_MODE_CYC (`CNTM_MODE_US * (`CNTM_CLK_HZ / 1000000))
`define CNTM_CNT_W 20
`endif

// ---- core/cntm_pkg.sv ----
// Types for the transceiver mode and wake control block
package cntm_pkg;
  typedef enum logic [1:0] {
    CNTM_NORMAL = 2'b01,
    CNTM_STANDBY = 2'b10
  } cntm_mode_t;
  typedef enum logic [3:0] {
    CNTM_W_IDLE = 4'b0001,
    CNTM_W_DOM1 = 4'b0010,
    CNTM_W_REC = 4'b0100,
    CNTM_W_DOM2 = 4'b1000
  } cntm_wstate_t;
endpackage : cntm_pkg

// ---- core/cntm_wake_det.sv ----
// Filtered dominant-recessive-dominant wake pattern detector
`timescale 1ns/100ps
`include "cntm_defs.svh"
module cntm_wake_det
  import cntm_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  cntm_wake_if.det wk
);
  localparam logic [`CNTM_CNT_W-1:0] PHASE_C = `CNTM_CNT_W'(`CNTM_WAKE_PHASE_CYC);
  localparam logic [`CNTM_CNT_W-1:0] TO_C = `CNTM_CNT_W'(`CNTM_WAKE_TO_CYC);
  cntm_wstate_t st_q, st_d;
  logic [`CNTM_CNT_W-1:0] ph_q, ph_d;
  logic [`CNTM_CNT_W-1:0] to_q, to_d;
  logic det_q, det_d;
  logic long_ph;

  // A phase only counts once it has lasted past the wake time, which drops glitches
  assign long_ph = (ph_q >= PHASE_C);
  assign wk.detected = det_q;

  always_comb begin
    st_d = st_q;
    // Saturates so a long quiet bus never wraps into a short phase
    ph_d = (ph_q == '1) ? ph_q : ph_q + `CNTM_CNT_W'(1);
    to_d = to_q;
    det_d = det_q;
    if (!wk.arm) begin
      st_d = CNTM_W_IDLE;
      ph_d = '0;
      to_d = '0;
      det_d = 1'b0;
    end else if (!det_q) begin
      if (st_q != CNTM_W_IDLE) begin
        to_d = to_q + `CNTM_CNT_W'(1);
      end
      unique case (st_q)
        CNTM_W_IDLE: begin
          if (wk.bus_dom) begin
            st_d = CNTM_W_DOM1;
            ph_d = '0;
            to_d = '0;
          end
        end
        CNTM_W_DOM1: begin
          // Short dominant phase restarts search; clamped bus stays here until the pattern timeout
          if (!wk.bus_dom) begin
            st_d = long_ph ? CNTM_W_REC : CNTM_W_IDLE;
            ph_d = '0;
          end
        end
        CNTM_W_REC: begin
          if (wk.bus_dom) begin
            st_d = long_ph ? CNTM_W_DOM2 : CNTM_W_DOM1;
            ph_d = '0;
            if (!long_ph) begin
              to_d = '0;
            end
          end
        end
        CNTM_W_DOM2: begin
          if (long_ph) begin
            det_d = 1'b1;
          end else if (!wk.bus_dom) begin
            st_d = CNTM_W_REC;
            ph_d = '0;
          end
        end
        default: begin
          st_d = CNTM_W_IDLE;
          ph_d = '0;
        end
      endcase
      if (st_q != CNTM_W_IDLE && to_q >= TO_C) begin
        st_d = CNTM_W_IDLE;
        ph_d = '0;
        to_d = '0;
        det_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_q <= CNTM_W_IDLE;
      ph_q <= '0;
      to_q <= '0;
      det_q <= 1'b0;
    end else if (ce_i) begin
      st_q <= st_d;
      ph_q <= ph_d;
      to_q <= to_d;
      det_q <= det_d;
    end
  end
endmodule : cntm_wake_det

// ---- core/cntm_wake_if.sv ----
// Signals between the mode controller and the wake detector
`timescale 1ns/100ps
interface cntm_wake_if;
  logic arm;
  logic bus_dom;
  logic detected;
  modport ctrl (output arm, output bus_dom, input detected);
  modport det (input arm, input bus_dom, output detected);
endinterface : cntm_wake_if

// ---- tb/cntm_ctrl_sva.sv ----
// Assertion checker for the transceiver mode and wake control block
`timescale 1ns/100ps
module cntm_ctrl_sva (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic txd_i,
  input wire logic txd_drv_i,
  input wire logic standby_select_i,
  input wire logic standby_select_drv_i,
  input wire logic bus_dom_i,
  input wire logic undervoltage_i,
  input wire logic thermal_shutdown_i,
  input wire logic rxd_o,
  input wire logic bus_drive_dom_o,
  input wire logic bus_bias_gnd_o,
  input wire logic normal_rx_en_o,
  input wire logic normal_mode_o,
  input wire logic dominant_timeout_o,
  input wire logic wake_flag_o
);
  logic [10:0] wait_d;
  logic [10:0] wait_q;
  // Cycles spent asking for normal mode while still in standby
  always_comb begin
    wait_d = 11'h000;
    if (standby_select_drv_i && !standby_select_i && !undervoltage_i && !normal_mode_o) begin
      wait_d = wait_q + 11'h001;
    end
  end
  always_ff @(posedge clk_i) begin
    wait_q <= resetn_i ? wait_d : 11'h000;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  chk_mode_stby: assert property (ce_i && (standby_select_i || !standby_select_drv_i
    || undervoltage_i) |=> !normal_mode_o) else $error("standby not entered");
  chk_mode_time: assert property (wait_q <= 11'h3e8) else $error("mode change slow");
  chk_bias_rx: assert property (bus_bias_gnd_o == !normal_mode_o
    && normal_rx_en_o == normal_mode_o) else $error("bias or receiver wrong");
  chk_tx_rec: assert property (txd_i || !txd_drv_i || !normal_mode_o
    |=> !bus_drive_dom_o) else $error("dominant without request");
  chk_tx_dom: assert property (normal_mode_o && standby_select_drv_i && !standby_select_i
    && !undervoltage_i && !thermal_shutdown_i && !$past(thermal_shutdown_i)
    && ($past(txd_i) || !$past(txd_drv_i)) && !txd_i && txd_drv_i |=> bus_drive_dom_o)
    else $error("no dominant");
  chk_rxd_norm: assert property (normal_mode_o && $past(normal_mode_o)
    |-> rxd_o == !$past(bus_dom_i)) else $error("receive wrong");
  chk_rxd_idle: assert property (!normal_mode_o && !$past(normal_mode_o) && !wake_flag_o
    && !$past(wake_flag_o) |-> rxd_o) else $error("receive low without wake");
  chk_rxd_hold: assert property ($rose(wake_flag_o) |-> rxd_o[*8])
    else $error("receive not held after wake");
  chk_wake_clr: assert property ((normal_mode_o && $past(normal_mode_o))
    || $past(undervoltage_i) |-> !wake_flag_o) else $error("wake flag kept");
  chk_dto_off: assert property (dominant_timeout_o && $past(dominant_timeout_o)
    |-> !bus_drive_dom_o) else $error("drive during timeout");
  chk_dto_rel: assert property ($fell(dominant_timeout_o)
    |-> $past(txd_i) || !$past(txd_drv_i) || !normal_mode_o) else $error("timeout freed early");
  chk_hot_off: assert property (thermal_shutdown_i |=> !bus_drive_dom_o)
    else $error("drive while hot");
endmodule : cntm_ctrl_sva
bind cntm_ctrl cntm_ctrl_sva cntm_ctrl_sva_i (.clk_i, .resetn_i, .ce_i, .txd_i, .txd_drv_i,
  .standby_select_i, .standby_select_drv_i, .bus_dom_i, .undervoltage_i, .thermal_shutdown_i,
  .rxd_o, .bus_drive_dom_o, .bus_bias_gnd_o, .normal_rx_en_o, .normal_mode_o,
  .dominant_timeout_o, .wake_flag_o);

// ---- tb/cntm_ctrl_test.sv ----
// Self-checking bench for the transceiver mode and wake control block
`timescale 1ns/100ps
module cntm_ctrl_test;
  logic clk_i, resetn_i, sleep, tx, flt, sflt, far_dom, uv, hot;
  logic txd, txd_drv, stb, stb_drv, rxd, drv, bias, rx_en, nrm, dominant_timeout, wk;
  int num_errors = 0;
  int checked = 0;
  int n;
  cntm_mcu_model cntm_mcu_model_i (.sleep_i(sleep), .tx_i(tx), .float_i(flt),
    .stb_float_i(sflt), .txd_o(txd),
    .txd_drv_o(txd_drv), .stb_o(stb), .stb_drv_o(stb_drv));
  cntm_ctrl cntm_ctrl_i (.clk_i, .resetn_i, .ce_i(1'h1), .txd_i(txd), .txd_drv_i(txd_drv),
    .standby_select_i(stb), .standby_select_drv_i(stb_drv), .bus_dom_i(drv | far_dom),
    .undervoltage_i(uv), .thermal_shutdown_i(hot), .rxd_o(rxd), .bus_drive_dom_o(drv),
    .bus_bias_gnd_o(bias), .normal_rx_en_o(rx_en), .normal_mode_o(nrm),
    .dominant_timeout_o(dominant_timeout), .wake_flag_o(wk));
  task automatic chk(input logic got, input logic exp, input string msg);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask : cyc
  // Leaves the cycles taken in n
  task automatic wait_for(ref logic s, input int lim);
    n = 0;
    while (s !== 1'h1 && n < lim) begin
      cyc(1);
      n++;
    end
  endtask : wait_for
  task automatic phase(input logic d, input int k);
    far_dom = d;
    cyc(k);
  endtask : phase
  task automatic t_wake;
    chk(rxd, 1'h1, "rxd reset");
    phase(1'h1, 5);
    phase(1'h0, 20);
    phase(1'h1, 5);
    phase(1'h0, 20);
    phase(1'h1, 2000);
    chk(wk, 1'h0, "filter");
    phase(1'h0, 14);
    phase(1'h1, 14);
    wait_for(wk, 20);
    chk(wk, 1'h1, "no wake");
    cyc(90);
    chk(rxd, 1'h1, "rxd early");
    cyc(420);
    chk(rxd, 1'h0, "rxd late");
    far_dom = 1'h0;
    uv = 1'h1;
    cyc(2);
    chk(wk, 1'h0, "uv flag");
    uv = 1'h0;
    $display("wake done");
  endtask : t_wake
  task automatic t_normal;
    sleep = 1'h0;
    wait_for(nrm, 1100);
    chk(n <= 1000, 1'h1, "mode slow");
    chk(bias, 1'h0, "bias");
    chk(rx_en, 1'h1, "rx en");
    tx = 1'h0;
    cyc(2);
    chk(drv, 1'h1, "no dom");
    chk(rxd, 1'h0, "rxd dom");
    flt = 1'h1;
    cyc(2);
    chk(drv, 1'h0, "float");
    chk(rxd, 1'h1, "rxd rec");
    flt = 1'h0;
    tx = 1'h1;
    $display("normal done");
  endtask : t_normal
  task automatic t_dto;
    cyc(2);
    tx = 1'h0;
    wait_for(dominant_timeout, 60000);
    chk(n >= 20000, 1'h1, "dto early");
    cyc(1);
    chk(drv, 1'h0, "dto drive");
    tx = 1'h1;
    cyc(2);
    chk(dominant_timeout, 1'h0, "dto kept");
    tx = 1'h0;
    cyc(2);
    chk(drv, 1'h1, "dto restart");
    tx = 1'h1;
    $display("timeout done");
  endtask : t_dto
  task automatic t_hot_uv;
    cyc(2);
    tx = 1'h0;
    hot = 1'h1;
    cyc(2);
    hot = 1'h0;
    cyc(3);
    chk(drv, 1'h0, "hot kept");
    tx = 1'h1;
    cyc(2);
    tx = 1'h0;
    cyc(2);
    chk(drv, 1'h1, "hot stuck");
    tx = 1'h1;
    uv = 1'h1;
    cyc(2);
    tx = 1'h0;
    cyc(198);
    chk(nrm, 1'h0, "uv mode");
    chk(drv, 1'h0, "uv drive");
    tx = 1'h1;
    uv = 1'h0;
    wait_for(nrm, 1100);
    chk(nrm, 1'h1, "uv stuck");
    sflt = 1'h1;
    cyc(2);
    chk(nrm, 1'h0, "float select");
    sflt = 1'h0;
    wait_for(nrm, 1100);
    sleep = 1'h1;
    cyc(2);
    chk(nrm, 1'h0, "standby");
    chk(bias, 1'h1, "standby bias");
    chk(rx_en, 1'h0, "standby rx en");
    $display("protect done");
  endtask : t_hot_uv
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  initial begin
    clk_i = 1'h0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    // Tests need about 53000 cycles, mostly the dominant timeout
    repeat (80000) @(posedge clk_i);
    num_errors++;
    test_done();
  end
  initial begin
    {resetn_i, flt, sflt, far_dom, uv, hot} = 6'h00;
    {sleep, tx} = 2'h3;
    cyc(2);
    resetn_i = 1'h1;
    t_wake();
    t_normal();
    t_dto();
    t_hot_uv();
    test_done();
  end
endmodule : cntm_ctrl_test

// ---- tb/cntm_mcu_model.sv ----
// Behavioural protocol controller driving transmit and standby select
`timescale 1ns/100ps
module cntm_mcu_model (
  input wire logic sleep_i,
  input wire logic tx_i,
  input wire logic float_i,
  input wire logic stb_float_i,
  output logic txd_o,
  output logic txd_drv_o,
  output logic stb_o,
  output logic stb_drv_o
);
  // Both held high in standby; a released line sits at its pull-up
  assign txd_o = sleep_i | tx_i | float_i;
  assign txd_drv_o = ~float_i;
  assign stb_o = sleep_i | stb_float_i;
  assign stb_drv_o = ~stb_float_i;
endmodule : cntm_mcu_model
